// ---- sbs_pkg.sv ----
// package for the byte-wide serial shifter with register front end
// assumes a 32-bit apb master and a 10 MHz system clock
package sbs_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] SBS_IDX_TX_HOLD   = 8'h29;
    localparam logic [7:0] SBS_IDX_RX_HOLD   = 8'h2A;
    localparam logic [7:0] SBS_IDX_CTRL      = 8'h2B;
    localparam logic [7:0] SBS_IDX_IRQ_STAT  = 8'h30;
    localparam logic [7:0] SBS_IDX_IRQ_EN    = 8'h31;
    localparam logic [7:0] SBS_IDX_IRQ_CLR   = 8'h32;
    localparam logic [7:0] SBS_IDX_CLK_DIV   = 8'h33;
    // control/status field positions
    localparam int SBS_B_LSB_FIRST = 7;
    localparam int SBS_B_OVERRUN   = 6;
    localparam int SBS_B_COMPLETE  = 5;
    localparam int SBS_B_TX_EMPTY  = 4;
    localparam int SBS_B_RX_FULL   = 3;
    localparam int SBS_B_PHASE     = 2;
    localparam int SBS_B_POLARITY  = 1;
    localparam int SBS_B_ENABLE    = 0;
    // interrupt status layout
    localparam int SBS_I_TX_EMPTY  = 0;
    localparam int SBS_I_COMPLETE  = 1;
    localparam int SBS_I_RX_FULL   = 2;
    localparam int SBS_I_OVERRUN   = 3;
    localparam int SBS_IRQ_W       = 4;
    // reset values and the last bit index
    localparam logic [7:0] SBS_HOLD_RST  = 8'h00;
    localparam logic [3:0] SBS_CFG_RST   = 4'h0;
    localparam logic [7:0] SBS_DIV_RST   = 8'h03;
    localparam logic [2:0] SBS_BITS_LAST = 3'h7;
    typedef enum logic [2:0] {
        SBS_IDLE  = 3'b001,
        SBS_FIRST = 3'b010,
        SBS_SECND = 3'b100
    } sbs_state_t;
endpackage

// ---- sbs_shifter.sv ----
// serial engine: one byte out and one byte in per transfer
// assumes sys_clk domain; miso already synchronised by the caller
`timescale 1ns/10ps
module sbs_shifter
    import sbs_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // configuration
    input  wire logic       lsb_first,
    input  wire logic       phase,
    input  wire logic       polarity,
    input  wire logic       enable,
    input  wire logic [7:0] half_div,
    // byte handshake
    input  wire logic       start,
    input  wire logic [7:0] tx_byte,
    output logic            busy,
    output logic            done,
    output logic [7:0]      rx_byte,
    // serial side
    input  wire logic       miso_sync,
    output logic            sclk,
    output logic            mosi
);
    sbs_state_t state_reg, state_next;
    logic [7:0] shift_reg;
    logic [7:0] cnt_reg;
    logic [2:0] bits_reg;
    logic       lead_reg;
    logic       tick;
    logic       out_bit;
    logic       in_bit_lsb;

    assign tick = (cnt_reg == 8'h00);
    assign out_bit = lsb_first ? shift_reg[0] : shift_reg[7];
    assign busy = (state_reg != SBS_IDLE);

    // state walk: first half = leading edge, second half = trailing edge
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SBS_IDLE:  if (start && enable) state_next = SBS_FIRST;
            SBS_FIRST: if (tick) state_next = SBS_SECND;
            SBS_SECND: if (tick) state_next = (bits_reg == SBS_BITS_LAST) ? SBS_IDLE : SBS_FIRST;
            default:   state_next = SBS_IDLE;
        endcase
        if (!enable) state_next = SBS_IDLE;
    end

    assign in_bit_lsb = lsb_first;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= SBS_IDLE;
            shift_reg <= SBS_HOLD_RST;
            cnt_reg   <= 8'h00;
            bits_reg  <= 3'h0;
            sclk      <= 1'b0;
            mosi      <= 1'b0;
            done      <= 1'b0;
            rx_byte   <= SBS_HOLD_RST;
            lead_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            done      <= 1'b0;
            cnt_reg   <= (state_reg == SBS_IDLE || tick) ? half_div : cnt_reg - 8'h01;
            if (state_reg == SBS_IDLE) begin
                sclk     <= polarity;
                bits_reg <= 3'h0;
                if (start && enable) begin
                    shift_reg <= tx_byte;
                    // phase 0 presents the first bit before the leading edge
                    if (!phase) mosi <= lsb_first ? tx_byte[0] : tx_byte[7];
                end
            end else if (tick && state_reg == SBS_FIRST) begin
                sclk <= ~polarity;
                if (phase) mosi <= out_bit;
                else lead_reg <= miso_sync;
            end else if (tick && state_reg == SBS_SECND) begin
                sclk     <= polarity;
                bits_reg <= bits_reg + 3'h1;
                // sample point depends on phase; shift in at the far end
                if (in_bit_lsb)
                    shift_reg <= {phase ? miso_sync : lead_reg, shift_reg[7:1]};
                else
                    shift_reg <= {shift_reg[6:0], phase ? miso_sync : lead_reg};
                if (!phase)
                    mosi <= lsb_first ? shift_reg[1] : shift_reg[6];
                if (bits_reg == SBS_BITS_LAST) begin
                    done    <= 1'b1;
                    rx_byte <= in_bit_lsb ? {phase ? miso_sync : lead_reg, shift_reg[7:1]}
                                          : {shift_reg[6:0], phase ? miso_sync : lead_reg};
                end
            end
        end
    end

    property p_idle_level;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_reg == SBS_IDLE) && $past(state_reg == SBS_IDLE) |-> sclk == $past(polarity);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("sclk not at idle level");

    property p_done_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        done |-> state_reg == SBS_IDLE && sclk == polarity;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done before clocks ended");

    property p_lead_edge;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(state_reg == SBS_SECND) |-> sclk == ~polarity;
    endproperty
    a_lead_edge: assert property (p_lead_edge) else $error("leading edge missing");
endmodule // sbs_shifter

// ---- sbs_spi_partner.sv ----
// behavioural far-side device on the serial pins, one byte each way
// assumes the bench pulses restart once mode inputs and sclk have settled
`timescale 1ns/10ps
module sbs_spi_partner (
    // serial pins
    input  wire logic       sclk,
    input  wire logic       mosi,
    output logic            miso,
    // mode and data from the bench
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       lsb_first,
    input  wire logic       restart,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte
);
    logic [2:0] n_in;
    logic [2:0] n_out;

    function automatic int pos(input logic [2:0] k);
        return lsb_first ? int'(k) : 7 - int'(k);
    endfunction

    initial begin
        miso = 1'b0;
    end

    // phase 1 starts with a value that is not yet data
    always @(posedge restart) begin
        n_in = 3'h0;
        n_out = cpha ? 3'h0 : 3'h1;
        miso = cpha ? ~miso : tx_byte[pos(3'h0)];
    end

    // sampling edge versus change edge
    always @(sclk) begin
        if (((sclk !== cpol) ^ cpha) == 1'b1) begin
            rx_byte[pos(n_in)] = mosi;
            n_in = n_in + 3'h1;
        end else begin
            miso = tx_byte[pos(n_out)];
            n_out = n_out + 3'h1;
        end
    end
endmodule // sbs_spi_partner

// ---- sbs_top.sv ----
// apb register front end with control/status, holding registers and irq
// assumes apb master on sys_clk; miso pin is asynchronous
`timescale 1ns/10ps
module sbs_top
    import sbs_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // serial pins
    input  wire logic        miso,
    output logic             sclk,
    output logic             mosi,
    // interrupt
    output logic             irq
);
    logic [7:0]  tx_hold_reg;
    logic [7:0]  rx_hold_reg;
    logic        lsb_first_reg;
    logic        phase_reg;
    logic        polarity_reg;
    logic        enable_reg;
    logic        overrun_reg;
    logic        complete_reg;
    logic        tx_full_reg;
    logic        rx_full_reg;
    logic        tx_armed_reg;
    logic [7:0]  div_reg;
    logic [SBS_IRQ_W-1:0] irq_stat_reg;
    logic [SBS_IRQ_W-1:0] irq_en_reg;
    logic        miso_s1_reg;
    logic        miso_s2_reg;
    logic        sh_busy;
    logic        sh_done;
    logic [7:0]  sh_rx;
    logic        sh_sclk;
    logic        sh_mosi;
    logic        sh_start;
    logic        acc;
    logic        wr;
    logic        rd;
    logic [7:0]  ctrl_fwd;
    logic        hit_tx;
    logic        hit_rx;
    logic        hit_ctrl;
    logic        hit_ist;
    logic        hit_ien;
    logic        hit_icl;
    logic        hit_div;
    logic        mapped;
    logic        ctrl_rd;
    logic        tx_wr;
    logic        ctrl_wr;
    logic [7:0]  ctrl_view;
    logic [31:0] rd_mux;
    logic [SBS_IRQ_W-1:0] ev;

    function automatic logic is_idx(input logic [11:0] a, input logic [7:0] i);
        return (a[1:0] == 2'b00) && (a[11:2] == {2'b00, i});
    endfunction

    // apb decode; answers in the first access cycle
    assign acc      = psel && penable && pready;
    assign wr       = acc && pwrite;
    assign rd       = acc && !pwrite;
    assign hit_tx   = is_idx(paddr, SBS_IDX_TX_HOLD);
    assign hit_rx   = is_idx(paddr, SBS_IDX_RX_HOLD);
    assign hit_ctrl = is_idx(paddr, SBS_IDX_CTRL);
    assign hit_ist  = is_idx(paddr, SBS_IDX_IRQ_STAT);
    assign hit_ien  = is_idx(paddr, SBS_IDX_IRQ_EN);
    assign hit_icl  = is_idx(paddr, SBS_IDX_IRQ_CLR);
    assign hit_div  = is_idx(paddr, SBS_IDX_CLK_DIV);
    assign mapped   = hit_tx | hit_rx | hit_ctrl | hit_ist | hit_ien | hit_icl | hit_div;
    assign ctrl_rd  = rd && hit_ctrl;
    assign ctrl_wr  = wr && hit_ctrl;
    assign tx_wr    = wr && hit_tx;

    // transmit-empty forced high while disabled
    assign ctrl_view = {lsb_first_reg, overrun_reg, complete_reg,
                        !tx_full_reg || !enable_reg, rx_full_reg,
                        phase_reg, polarity_reg, enable_reg};

    // a byte ending in the setup cycle is shown now, so the read clear cannot lose it
    assign ctrl_fwd = ctrl_view | ({7'h00, sh_done && rx_full_reg} << SBS_B_OVERRUN)
                                | ({7'h00, sh_done} << SBS_B_COMPLETE)
                                | ({7'h00, sh_done} << SBS_B_RX_FULL);

    assign rd_mux = hit_rx   ? {24'h000000, sh_done ? sh_rx : rx_hold_reg} :
                    hit_ctrl ? {24'h000000, ctrl_fwd} :
                    hit_ist  ? {28'h0000000, irq_stat_reg} :
                    hit_ien  ? {28'h0000000, irq_en_reg} :
                    hit_div  ? {24'h000000, div_reg} : 32'h00000000;

    // start when a byte waits and the engine is free
    assign sh_start = enable_reg && tx_full_reg && !sh_busy;

    assign ev[SBS_I_TX_EMPTY] = sh_start && tx_armed_reg;
    assign ev[SBS_I_COMPLETE] = sh_done;
    assign ev[SBS_I_RX_FULL]  = sh_done;
    assign ev[SBS_I_OVERRUN]  = sh_done && rx_full_reg;

    // apb answer registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // configuration and holding registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lsb_first_reg <= 1'b0;
            phase_reg     <= 1'b0;
            polarity_reg  <= 1'b0;
            enable_reg    <= 1'b0;
            tx_hold_reg   <= SBS_HOLD_RST;
            div_reg       <= SBS_DIV_RST;
            irq_en_reg    <= {SBS_IRQ_W{1'b0}};
        end else begin
            if (ctrl_wr) begin
                lsb_first_reg <= pwdata[SBS_B_LSB_FIRST];
                phase_reg     <= pwdata[SBS_B_PHASE];
                polarity_reg  <= pwdata[SBS_B_POLARITY];
                enable_reg    <= pwdata[SBS_B_ENABLE];
            end
            if (tx_wr) tx_hold_reg <= pwdata[7:0];
            if (wr && hit_div) div_reg <= pwdata[7:0];
            if (wr && hit_ien) irq_en_reg <= pwdata[SBS_IRQ_W-1:0];
        end
    end

    // status flags; hardware set wins over read clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            overrun_reg  <= 1'b0;
            complete_reg <= 1'b0;
            tx_full_reg  <= 1'b0;
            rx_full_reg  <= 1'b0;
            rx_hold_reg  <= SBS_HOLD_RST;
            tx_armed_reg <= 1'b0;
        end else begin
            if (sh_done) overrun_reg <= rx_full_reg || (overrun_reg && !ctrl_rd);
            else if (ctrl_rd) overrun_reg <= 1'b0;
            if (sh_done) complete_reg <= 1'b1;
            else if (ctrl_rd) complete_reg <= 1'b0;
            if (!enable_reg) tx_full_reg <= 1'b0;
            else if (tx_wr) tx_full_reg <= 1'b1;
            else if (sh_start) tx_full_reg <= 1'b0;
            if (sh_done) begin
                rx_hold_reg <= sh_rx;
                rx_full_reg <= 1'b1;
            end else if (rd && hit_rx) rx_full_reg <= 1'b0;
            if (!enable_reg) tx_armed_reg <= 1'b0;
            else if (sh_start) tx_armed_reg <= 1'b1;
        end
    end

    // interrupt status: set wins over clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_stat_reg <= {SBS_IRQ_W{1'b0}};
            irq          <= 1'b0;
        end else begin
            irq_stat_reg <= ev | (irq_stat_reg & ~((wr && hit_icl) ? pwdata[SBS_IRQ_W-1:0]
                                                                     : {SBS_IRQ_W{1'b0}}));
            irq          <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // miso pin synchroniser
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            miso_s1_reg <= 1'b0;
            miso_s2_reg <= 1'b0;
        end else begin
            miso_s1_reg <= miso;
            miso_s2_reg <= miso_s1_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sclk <= 1'b0;
            mosi <= 1'b0;
        end else begin
            sclk <= sh_sclk;
            mosi <= sh_mosi;
        end
    end

    sbs_shifter u_shift (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .lsb_first (lsb_first_reg),
        .phase     (phase_reg),
        .polarity  (polarity_reg),
        .enable    (enable_reg),
        .half_div  (div_reg),
        .start     (sh_start),
        .tx_byte   (tx_hold_reg),
        .busy      (sh_busy),
        .done      (sh_done),
        .rx_byte   (sh_rx),
        .miso_sync (miso_s2_reg),
        .sclk      (sh_sclk),
        .mosi      (sh_mosi)
    );

    property p_ovr_set;
        @(posedge sys_clk) disable iff (sys_rst)
        sh_done && rx_full_reg |=> overrun_reg;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not set");

    property p_cpl_clr;
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl_rd && !sh_done |=> !complete_reg && !overrun_reg;
    endproperty
    a_cpl_clr: assert property (p_cpl_clr) else $error("flags not cleared by read");

    property p_cpl_set;
        @(posedge sys_clk) disable iff (sys_rst)
        sh_done |=> complete_reg && rx_full_reg && rx_hold_reg == $past(sh_rx);
    endproperty
    a_cpl_set: assert property (p_cpl_set) else $error("byte end not recorded");

    property p_rxf_clr;
        @(posedge sys_clk) disable iff (sys_rst)
        rd && hit_rx && !sh_done |=> !rx_full_reg;
    endproperty
    a_rxf_clr: assert property (p_rxf_clr) else $error("rx full not cleared");

    property p_txe_dis;
        @(posedge sys_clk) disable iff (sys_rst)
        pready && !pwrite && hit_ctrl && !enable_reg |-> prdata[SBS_B_TX_EMPTY];
    endproperty
    a_txe_dis: assert property (p_txe_dis) else $error("tx empty low while disabled");

    property p_txe_wr;
        @(posedge sys_clk) disable iff (sys_rst)
        tx_wr && enable_reg && sh_busy |=> !ctrl_view[SBS_B_TX_EMPTY];
    endproperty
    a_txe_wr: assert property (p_txe_wr) else $error("tx empty kept after write");

    property p_first_irq;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(enable_reg) |-> !irq_stat_reg[SBS_I_TX_EMPTY] || $past(irq_stat_reg[SBS_I_TX_EMPTY]);
    endproperty
    a_first_irq: assert property (p_first_irq) else $error("tx empty irq on enable");

    property p_irq_lvl;
        @(posedge sys_clk) disable iff (sys_rst)
        |(irq_stat_reg & irq_en_reg) |=> irq;
    endproperty
    a_irq_lvl: assert property (p_irq_lvl) else $error("irq not raised");

    property p_ctrl_show;
        @(posedge sys_clk) disable iff (sys_rst)
        pready && !pwrite && hit_ctrl && $past(sh_done) |-> prdata[SBS_B_COMPLETE];
    endproperty
    a_ctrl_show: assert property (p_ctrl_show) else $error("byte end hidden from read");

    property p_ctrl_set;
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl_rd && sh_done |=> complete_reg;
    endproperty
    a_ctrl_set: assert property (p_ctrl_set) else $error("byte end lost in read");

    property p_rx_show;
        @(posedge sys_clk) disable iff (sys_rst)
        pready && !pwrite && hit_rx && $past(sh_done) |-> prdata[7:0] == rx_hold_reg;
    endproperty
    a_rx_show: assert property (p_rx_show) else $error("new byte not shown");

    property p_apb_ans;
        @(posedge sys_clk) disable iff (sys_rst)
        psel && !penable |=> pready;
    endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("no answer in access cycle");

    property p_rd_wo;
        @(posedge sys_clk) disable iff (sys_rst)
        pready && !pwrite && hit_tx |-> prdata == 32'h00000000;
    endproperty
    a_rd_wo: assert property (p_rd_wo) else $error("tx holding readable");

    property p_txe_en;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(enable_reg) |-> ctrl_view[SBS_B_TX_EMPTY];
    endproperty
    a_txe_en: assert property (p_txe_en) else $error("tx empty low on enable");

    property p_tx_flush;
        @(posedge sys_clk) disable iff (sys_rst)
        !enable_reg |=> !tx_full_reg;
    endproperty
    a_tx_flush: assert property (p_tx_flush) else $error("byte kept while disabled");

    property p_dis_abort;
        @(posedge sys_clk) disable iff (sys_rst)
        !enable_reg |=> !sh_busy;
    endproperty
    a_dis_abort: assert property (p_dis_abort) else $error("engine runs while disabled");

    property p_ovr_keep;
        @(posedge sys_clk) disable iff (sys_rst)
        overrun_reg && !ctrl_rd |=> overrun_reg;
    endproperty
    a_ovr_keep: assert property (p_ovr_keep) else $error("overrun dropped");

    property p_cpl_keep;
        @(posedge sys_clk) disable iff (sys_rst)
        complete_reg && !ctrl_rd |=> complete_reg;
    endproperty
    a_cpl_keep: assert property (p_cpl_keep) else $error("complete dropped");

    property p_rxf_keep;
        @(posedge sys_clk) disable iff (sys_rst)
        rx_full_reg && !(rd && hit_rx) |=> rx_full_reg;
    endproperty
    a_rxf_keep: assert property (p_rxf_keep) else $error("rx full dropped");

    property p_tx_land;
        @(posedge sys_clk) disable iff (sys_rst)
        tx_wr |=> tx_hold_reg == $past(pwdata[7:0]);
    endproperty
    a_tx_land: assert property (p_tx_land) else $error("tx byte not stored");

    property p_irq_off;
        @(posedge sys_clk) disable iff (sys_rst)
        !(|(irq_stat_reg & irq_en_reg)) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq without enabled source");
endmodule // sbs_top

// ---- test_sbs_top.sv ----
// self-checking bench for the serial shifter register block
// assumes the partner model stands on the serial pins
`timescale 1ns/10ps
module test_sbs_top;
    import sbs_pkg::*;
    logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic        miso, sclk, mosi, irq, cpol, cpha, lsbf, restart;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  p_tx, p_rx;
    int          miscompares, n_tests;

    sbs_top u_sbs_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .miso(miso), .sclk(sclk), .mosi(mosi), .irq(irq));
    sbs_spi_partner u_sbs_spi_partner (.sclk(sclk), .mosi(mosi), .miso(miso), .cpol(cpol),
        .cpha(cpha), .lsb_first(lsbf), .restart(restart), .tx_byte(p_tx), .rx_byte(p_rx));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer, entered right after a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge sys_clk);
        end
        if (pready !== 1'b1) miscompares++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic e;
        apb(1'b1, idx, {24'h0, d}, e);
    endtask

    task automatic rd(input logic [7:0] idx);
        logic e;
        apb(1'b0, idx, 32'h0, e);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        rd(SBS_IDX_CTRL);
        while (r[SBS_B_COMPLETE] !== 1'b1 && n < 100) begin
            n++;
            rd(SBS_IDX_CTRL);
        end
        if (r[SBS_B_COMPLETE] !== 1'b1) miscompares++;
    endtask

    // partner takes the same mode, then restarts its bit counts
    task automatic go(input logic pol, input logic ph, input logic lsb);
        cpol <= pol;
        cpha <= ph;
        lsbf <= lsb;
        repeat (3) @(posedge sys_clk);
        restart <= 1'b1;
        @(posedge sys_clk);
        restart <= 1'b0;
    endtask

    task automatic t_reset();
        logic e;
        rd(SBS_IDX_CTRL);
        chk(r, 32'h10, "ctrl after reset");
        rd(SBS_IDX_RX_HOLD);
        chk(r, 32'h0, "rx after reset");
        wr(SBS_IDX_RX_HOLD, 8'h55);
        rd(SBS_IDX_RX_HOLD);
        chk(r, 32'h0, "rx not writable");
        apb(1'b0, 8'h2C, 32'h0, e);
        chk({r[30:0], e}, 32'h1, "unmapped read");
        chk({31'h0, irq}, 32'h0, "irq idle");
    endtask

    task automatic t_modes();
        logic [7:0] tb [4] = '{8'hB1, 8'h2C, 8'h93, 8'h0E};
        logic [7:0] cfg;
        for (int m = 0; m < 4; m++) begin
            cfg = {m[0] ^ m[1], 4'h0, m[1], m[0], 1'b1};
            p_tx <= ~tb[m];
            wr(SBS_IDX_CTRL, cfg);
            go(m[0], m[1], cfg[7]);
            chk({31'h0, sclk}, {31'h0, cfg[1]}, "sclk idle");
            wr(SBS_IDX_TX_HOLD, tb[m]);
            wait_done();
            chk(r, {24'h0, cfg | 8'h38}, "ctrl done");
            chk({24'h0, p_rx}, {24'h0, tb[m]}, "byte out");
            rd(SBS_IDX_RX_HOLD);
            chk(r, {24'h0, ~tb[m]}, "byte in");
            rd(SBS_IDX_CTRL);
            chk(r, {24'h0, cfg | 8'h10}, "flags cleared");
            wr(SBS_IDX_CTRL, 8'h00);
            rd(SBS_IDX_CTRL);
            chk(r, 32'h10, "disabled");
        end
    endtask

    task automatic t_overrun();
        wr(SBS_IDX_IRQ_CLR, 8'h0F);
        wr(SBS_IDX_IRQ_EN, 8'h03);
        p_tx <= 8'h3C;
        wr(SBS_IDX_CTRL, 8'h01);
        go(1'b0, 1'b0, 1'b0);
        wr(SBS_IDX_TX_HOLD, 8'hA5);
        wr(SBS_IDX_TX_HOLD, 8'h5A);
        rd(SBS_IDX_CTRL);
        chk(r, 32'h01, "byte waiting");
        rd(SBS_IDX_IRQ_STAT);
        chk(r, 32'h0, "first move quiet");
        wait_done();
        wait_done();
        chk(r, 32'h79, "overrun seen");
        rd(SBS_IDX_IRQ_STAT);
        chk(r, 32'hF, "irq status");
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(SBS_IDX_IRQ_EN, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(SBS_IDX_IRQ_EN, 8'h03);
        wr(SBS_IDX_IRQ_CLR, 8'h0F);
        repeat (2) @(posedge sys_clk);
        rd(SBS_IDX_IRQ_STAT);
        chk(r, 32'h0, "irq cleared");
        chk({31'h0, irq}, 32'h0, "irq low");
        rd(SBS_IDX_RX_HOLD);
        chk(r, 32'h3C, "last byte kept");
        rd(SBS_IDX_CTRL);
        chk(r, 32'h11, "overrun cleared");
        wr(SBS_IDX_CTRL, 8'h00);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        miscompares++;
        close_out();
    end

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cpol = 1'b0;
        cpha = 1'b0;
        lsbf = 1'b0;
        restart = 1'b0;
        p_tx = 8'h00;
        miscompares = 0;
        n_tests = 0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_modes();
        t_overrun();
        close_out();
    end
endmodule // test_sbs_top
